// file: verilog/field_mem_defines.svh
// Constants for the field memory host controller
`ifndef FIELD_MEM_DEFINES_SVH
`define FIELD_MEM_DEFINES_SVH

`define WORD_WIDTH       12
`define FIFO_DEPTH       16
`define SYS_CLK_NS       100
`define POWER_UP_WAIT_NS 100000
`define POWER_UP_CYCLES  ((`POWER_UP_WAIT_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define MIN_ACTIVE       80
`define MIN_RESET_GAP    2
`define OLD_DATA_MAX     70
`define NEW_DATA_MIN     600

`endif

// file: verilog/field_mem_pkg.sv
// Types for the field memory host controller
package field_mem_pkg;

   typedef enum logic [2:0] {
      ST_INIT   = 3'h0,
      ST_DUMMY1 = 3'h1,
      ST_RST1   = 3'h3,
      ST_DUMMY2 = 3'h2,
      ST_RST2   = 3'h6,
      ST_RUN    = 3'h7
   } host_state_t;

endpackage

// file: verilog/word_fifo.sv
// Word FIFO with valid/ready on both sides and registered flags
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    next_rdPtr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   always_comb begin
      push       = inValid && inReady;
      pop        = outValid && outReady;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_count = count;
      if (push) begin
         next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
      end
      if (pop) begin
         next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
      end
      if (push && !pop) begin
         next_count = count + (AW+1)'(1);
      end else if (pop && !push) begin
         next_count = count - (AW+1)'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr    <= '0;
         rdPtr    <= '0;
         count    <= '0;
         inReady  <= 1'b0;
         outValid <= 1'b0;
      end else begin
         wrPtr    <= next_wrPtr;
         rdPtr    <= next_rdPtr;
         count    <= next_count;
         inReady  <= (next_count != (AW+1)'(DEPTH));
         outValid <= (next_count != '0);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   assign outData = mem[rdPtr];
endmodule

// file: verilog/field_mem_host.sv
// Host controller driving the serial ports of a field memory
// Behaviour
// R1 - Write pointer clears on first write clock rise with write reset high.
// R2 - Gate levels are ignored by the memory during a write reset cycle.
// R3 - Keep write reset low at least two write clocks between resets.
// R4 - At least 80 active write cycles follow each write reset.
// R5 - A write reset after the last word moves it into the array.
// R6 - Write clock rise with pointer gate high captures word and advances.
// R7 - Data gate only selects storing; pointer advances regardless.
// R8 - Memory write timing lags read timing by one clock.
// R9 - Read pointer clears on first read clock rise with read reset high.
// R10 - Gate levels are ignored by the memory during a read reset cycle.
// R11 - Keep read reset low at least two read clocks between resets.
// R12 - At least 80 active read cycles follow each read reset.
// R13 - Read clock rise with gate high shifts next word and advances.
// R14 - Output gate only enables drivers; pointer advances regardless.
// R15 - After 100 us, 80 clocks each side, then write and read reset.
// R16 - Unsure supplies: reset, 80 clocks, reset again on each side.
// R17 - Leave at least 600 write clocks between writing and reading data.
// R18 - Read reset under 70 clocks after write reset reads old field.
// R19 - Read reset at least 600 clocks after write reset reads new field.
// R20 - Spacing between 71 and 600 gives mixed data; avoid it.
// R21 - Memory keeps data and pointers while clocks stop; self refresh.
// R22 - Memory holds 12-bit words in 512 by 512 array, two pointers.
// R23 - With output gate low the memory releases its data outputs.
`timescale 1ns/10ps
`include "field_mem_defines.svh"
module field_mem_host
   import field_mem_pkg::*;
#(
   parameter int WORD_W = `WORD_WIDTH,
   parameter int DEPTH  = `FIFO_DEPTH
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              inValid,
   output logic                   inReady,
   input  wire logic [WORD_W-1:0] inData,
   input  wire logic              inStore,
   input  wire logic              writeFieldEnd,
   input  wire logic              readFieldStart,
   input  wire logic              readEnable,
   output logic                   outValid,
   output logic      [WORD_W-1:0] outData,
   output logic                   initDone,
   output logic                   writeResetPending,
   output logic                   readResetPending,
   output logic                   serialWriteClock,
   output logic                   serialReadClock,
   output logic                   writePointerReset,
   output logic                   readPointerReset,
   output logic                   writePointerGate,
   output logic                   writeDataGate,
   output logic                   readPointerGate,
   output logic                   outputGate,
   output logic      [WORD_W-1:0] serialInputWord,
   input  wire logic [WORD_W-1:0] serialOutputWord
);
   host_state_t       state;
   host_state_t       next_state;
   logic              phase;
   logic              next_phase;
   logic [9:0]        waitCnt;
   logic [9:0]        next_waitCnt;
   logic [6:0]        dummyCnt;
   logic [6:0]        next_dummyCnt;
   logic [6:0]        wrActive;
   logic [6:0]        next_wrActive;
   logic [6:0]        rdActive;
   logic [6:0]        next_rdActive;
   logic [1:0]        wrGap;
   logic [1:0]        next_wrGap;
   logic [1:0]        rdGap;
   logic [1:0]        next_rdGap;
   logic [9:0]        sinceWr;
   logic [9:0]        next_sinceWr;
   logic [2:0]        fetch;
   logic [2:0]        next_fetch;
   logic              next_initDone;
   logic              next_wrReq;
   logic              next_rdReq;
   logic              next_wrReset;
   logic              next_rdReset;
   logic              next_wrGate;
   logic              next_wrStore;
   logic              next_rdGate;
   logic              next_outGate;
   logic [WORD_W-1:0] next_inWord;
   logic              next_outValid;
   logic [WORD_W-1:0] next_outData;
   logic [WORD_W-1:0] rdSync1;
   logic [WORD_W-1:0] rdSync2;
   logic              fifoValid;
   logic              pop;
   logic [WORD_W:0]   fifoData;
   logic              rdWindowOk;

   word_fifo #(.WIDTH(WORD_W + 1), .DEPTH(DEPTH)) u_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .inValid  (inValid),
      .inReady  (inReady),
      .inData   ({inStore, inData}),
      .outValid (fifoValid),
      .outReady (pop),
      .outData  (fifoData)
   );

   // The reset lands one memory clock later: old field below 69 here, new from 600
   assign rdWindowOk = (sinceWr < 10'(`OLD_DATA_MAX - 1)) || (sinceWr >= 10'(`NEW_DATA_MIN)); // R17 R18 R19 R20

   always_comb begin
      next_state    = state;
      next_phase    = (state == ST_INIT) ? 1'b0 : ~phase;
      next_waitCnt  = waitCnt;
      next_dummyCnt = dummyCnt;
      next_wrActive = wrActive;
      next_rdActive = rdActive;
      next_wrGap    = wrGap;
      next_rdGap    = rdGap;
      next_sinceWr  = sinceWr;
      next_fetch    = {fetch[1:0], 1'b0};
      next_wrReset  = writePointerReset;
      next_rdReset  = readPointerReset;
      next_wrGate   = writePointerGate;
      next_wrStore  = writeDataGate;
      next_rdGate   = readPointerGate;
      next_outGate  = outputGate;
      next_inWord   = serialInputWord;
      next_wrReq    = writeResetPending;
      next_rdReq    = readResetPending;
      next_outValid = fetch[2];
      next_outData  = fetch[2] ? rdSync2 : outData;
      pop           = 1'b0;
      if (state == ST_INIT) begin
         next_waitCnt = waitCnt + 10'h001;
         if (waitCnt == 10'(`POWER_UP_CYCLES - 1)) begin
            next_state = ST_DUMMY1; // R15
         end
      end else if (!phase) begin
         // Rising edge: the memory samples the pins driven last half period
         next_wrGap    = writePointerReset ? 2'h0 : ((wrGap == 2'h3) ? wrGap : wrGap + 2'h1);
         next_rdGap    = readPointerReset ? 2'h0 : ((rdGap == 2'h3) ? rdGap : rdGap + 2'h1);
         next_sinceWr  = writePointerReset ? 10'h000 :
                         ((sinceWr == 10'(`NEW_DATA_MIN)) ? sinceWr : sinceWr + 10'h001);
         next_wrActive = writePointerReset ? 7'h00 :
                         ((writePointerGate && wrActive != 7'(`MIN_ACTIVE)) ? wrActive + 7'h01 : wrActive); // R4
         next_rdActive = readPointerReset ? 7'h00 :
                         ((readPointerGate && rdActive != 7'(`MIN_ACTIVE)) ? rdActive + 7'h01 : rdActive); // R12
         next_fetch[0] = (state == ST_RUN) && readPointerGate && !readPointerReset; // R13
         if (state == ST_DUMMY1 || state == ST_DUMMY2) begin
            next_dummyCnt = dummyCnt + 7'h01;
            if (dummyCnt == 7'(`MIN_ACTIVE)) begin
               next_dummyCnt = 7'h00;
               next_state    = (state == ST_DUMMY1) ? ST_RST1 : ST_RST2; // R15 R16
            end
         end
      end else begin
         // Falling edge: set up pins for the next rising edge
         next_wrReset = 1'b0;
         next_rdReset = 1'b0;
         next_wrGate  = 1'b0;
         next_wrStore = 1'b0;
         next_rdGate  = 1'b0;
         next_outGate = 1'b0;
         unique case (state)
            ST_DUMMY1, ST_DUMMY2: begin
               next_wrGate = 1'b1;
               next_rdGate = 1'b1;
            end
            ST_RST1, ST_RST2: begin
               next_wrReset = 1'b1; // R15 R16
               next_rdReset = 1'b1; // R15 R16
               next_state   = (state == ST_RST1) ? ST_DUMMY2 : ST_RUN;
            end
            ST_RUN: begin
               // Gates stay low in reset cycles; the memory ignores them anyway
               if (writePointerResetReady()) begin
                  next_wrReset = 1'b1; // R1 R3 R4 R5
                  next_wrReq   = 1'b0;
               end else if (fifoValid) begin
                  pop          = 1'b1;
                  next_wrGate  = 1'b1; // R6
                  next_wrStore = fifoData[WORD_W]; // R7
                  next_inWord  = fifoData[WORD_W-1:0];
               end
               if (readResetPending && rdActive == 7'(`MIN_ACTIVE) && rdGap >= 2'(`MIN_RESET_GAP) && rdWindowOk) begin
                  next_rdReset = 1'b1; // R9 R11 R12 R19
                  next_rdReq   = 1'b0;
               end else begin
                  next_rdGate  = readEnable; // R13
                  next_outGate = readEnable; // R14 R23
               end
            end
            default: ;
         endcase
      end
      // A new request in the cycle of issue is kept
      if (writeFieldEnd) begin
         next_wrReq = 1'b1;
      end
      if (readFieldStart) begin
         next_rdReq = 1'b1;
      end
      next_initDone = (next_state == ST_RUN);
   end

   function automatic logic writePointerResetReady();
      return writeResetPending && wrActive == 7'(`MIN_ACTIVE) && wrGap >= 2'(`MIN_RESET_GAP);
   endfunction

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state             <= ST_INIT;
         phase             <= 1'b0;
         waitCnt           <= 10'h000;
         dummyCnt          <= 7'h00;
         wrActive          <= 7'h00;
         rdActive          <= 7'h00;
         wrGap             <= 2'h0;
         rdGap             <= 2'h0;
         sinceWr           <= 10'h000;
         fetch             <= 3'h0;
         initDone          <= 1'b0;
         writeResetPending <= 1'b0;
         readResetPending  <= 1'b0;
         writePointerReset <= 1'b0;
         readPointerReset  <= 1'b0;
         writePointerGate  <= 1'b0;
         writeDataGate     <= 1'b0;
         readPointerGate   <= 1'b0;
         outputGate        <= 1'b0;
         serialInputWord   <= '0;
         outValid          <= 1'b0;
         outData           <= '0;
         rdSync1           <= '0;
         rdSync2           <= '0;
      end else begin
         state             <= next_state;
         phase             <= next_phase;
         waitCnt           <= next_waitCnt;
         dummyCnt          <= next_dummyCnt;
         wrActive          <= next_wrActive;
         rdActive          <= next_rdActive;
         wrGap             <= next_wrGap;
         rdGap             <= next_rdGap;
         sinceWr           <= next_sinceWr;
         fetch             <= next_fetch;
         initDone          <= next_initDone;
         writeResetPending <= next_wrReq;
         readResetPending  <= next_rdReq;
         writePointerReset <= next_wrReset;
         readPointerReset  <= next_rdReset;
         writePointerGate  <= next_wrGate;
         writeDataGate     <= next_wrStore;
         readPointerGate   <= next_rdGate;
         outputGate        <= next_outGate;
         serialInputWord   <= next_inWord;
         outValid          <= next_outValid;
         outData           <= next_outData;
         rdSync1           <= serialOutputWord;
         rdSync2           <= rdSync1;
      end
   end

   // Clocks run free once out of the wait; the memory would tolerate stops
   assign serialWriteClock = phase;
   assign serialReadClock  = phase;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   wr_reset_width_a: assert property ($rose(writePointerReset) |=> writePointerReset ##1 !writePointerReset) // R1
      else $error("write reset not one full write clock");
   wr_reset_gap_a: assert property ($fell(writePointerReset) |-> (!writePointerReset)[*4]) // R3
      else $error("write reset low under two write clocks");
   rd_reset_gap_a: assert property ($fell(readPointerReset) |-> (!readPointerReset)[*4]) // R11
      else $error("read reset low under two read clocks");
   wr_active_min_a: assert property ($rose(writePointerReset) && initDone |-> wrActive == 7'(`MIN_ACTIVE)) // R4
      else $error("write reset before 80 active writes");
   rd_active_min_a: assert property ($rose(readPointerReset) && initDone |-> rdActive == 7'(`MIN_ACTIVE)) // R12
      else $error("read reset before 80 active reads");
   rd_window_a: assert property ($rose(readPointerReset) && initDone && !writePointerReset |-> rdWindowOk) // R20
      else $error("read reset in mixed data band");
   wr_word_a: assert property (pop |=> writePointerGate && {writeDataGate, serialInputWord} == $past(fifoData)) // R6
      else $error("popped word not presented on write port");
   rd_fetch_a: assert property ($rose(serialReadClock) && readPointerGate && !readPointerReset && initDone
                                |-> ##3 outValid) // R13
      else $error("read word not delivered");
   init_wait_a: assert property ($past(state) == ST_INIT && state != ST_INIT
                                 |-> $past(waitCnt) == 10'(`POWER_UP_CYCLES - 1)) // R15
      else $error("power-up wait cut short");
   init_reset_pair_a: assert property (!initDone |-> writePointerReset == readPointerReset) // R16
      else $error("initial resets not paired");

   init_done_c: cover property ($rose(initDone));
   field_close_c: cover property ($rose(writePointerReset) && initDone);
   new_read_c: cover property ($rose(readPointerReset) && initDone && sinceWr >= 10'(`NEW_DATA_MIN));
   old_read_c: cover property ($rose(readPointerReset) && initDone && sinceWr < 10'(`OLD_DATA_MAX));
endmodule

// file: testbench/field_mem_model.sv
// Behavioural field memory answering the host controller
`timescale 1ns/10ps
module field_mem_model (
   input  wire logic        serialWriteClock,
   input  wire logic        serialReadClock,
   input  wire logic        writePointerReset,
   input  wire logic        readPointerReset,
   input  wire logic        writePointerGate,
   input  wire logic        writeDataGate,
   input  wire logic        readPointerGate,
   input  wire logic        outputGate,
   input  wire logic [11:0] serialInputWord,
   output logic      [11:0] serialOutputWord,
   output int               violations
);
   // Static array: stopped clocks lose nothing
   logic [11:0] mem [262144];
   logic [11:0] oldMem [262144];
   logic [7:0]  fieldTag [262144];
   logic [17:0] wrPtr    = 18'h00000;
   logic [17:0] rdPtr    = 18'h00000;
   logic [11:0] shiftOut = 12'h000;
   logic [7:0]  field    = 8'h01;
   logic        oldRead  = 1'b0;
   int          sinceWr  = 1000;
   int          wrActive = 0;
   int          rdActive = 0;
   int          wrLow    = 2;
   int          rdLow    = 2;
   initial violations = 0;
   always @(posedge serialWriteClock) begin
      // Nonblocking: the read side sees the pre-edge count in either order
      sinceWr <= writePointerReset ? 0 : sinceWr + 1;
      if (writePointerReset) begin
         if (wrLow < 2 || wrActive < 80) violations++;
         wrPtr = 18'h00000;
         wrActive = 0;
         field++;
      end else if (writePointerGate) begin
         if (writeDataGate) begin
            // Keep the previous field for a late read start
            if (fieldTag[wrPtr] !== field) oldMem[wrPtr] = mem[wrPtr];
            fieldTag[wrPtr] = field;
            // Captured on the edge itself; cascade lag is not modelled
            mem[wrPtr] = serialInputWord;
         end
         wrPtr++;
         wrActive++;
      end
      wrLow = writePointerReset ? 0 : wrLow + 1;
   end
   always @(posedge serialReadClock) begin
      if (readPointerReset) begin
         if (rdLow < 2 || rdActive < 80) violations++;
         // Simultaneous resets, at start-up or in run, are exempt from the band check
         if (!writePointerReset && sinceWr + 1 > 71 && sinceWr + 1 < 600) violations++;
         oldRead = writePointerReset || sinceWr + 1 < 70;
         rdPtr = 18'h00000;
         rdActive = 0;
      end else if (readPointerGate) begin
         shiftOut = (oldRead && fieldTag[rdPtr] === field) ? oldMem[rdPtr] : mem[rdPtr];
         rdPtr++;
         rdActive++;
      end
      rdLow = readPointerReset ? 0 : rdLow + 1;
   end
   // Released lines show the inverse, never a kind leftover
   assign serialOutputWord = outputGate ? shiftOut : ~shiftOut;
endmodule

// file: testbench/field_mem_host_bench.sv
// Random and corner-case bench for the field memory host controller
`timescale 1ns/10ps
module field_mem_host_bench;
   logic        sys_clk, rst, inValid, inReady, inStore, writeFieldEnd, readFieldStart;
   logic        readEnable, outValid, initDone, writeResetPending, readResetPending;
   logic        serialWriteClock, serialReadClock, writePointerReset, readPointerReset;
   logic        writePointerGate, writeDataGate, readPointerGate, outputGate, sawFull;
   logic [11:0] inData, outData, serialInputWord, serialOutputWord;
   logic [11:0] a [100];
   logic [11:0] w [100];
   logic        st [100];
   logic [31:0] seed;
   int          nFail, cmpCount, firstRise, violations, n;

   field_mem_host u_field_mem_host (
      .sys_clk, .rst, .inValid, .inReady, .inData, .inStore, .writeFieldEnd, .readFieldStart,
      .readEnable, .outValid, .outData, .initDone, .writeResetPending, .readResetPending,
      .serialWriteClock, .serialReadClock, .writePointerReset, .readPointerReset,
      .writePointerGate, .writeDataGate, .readPointerGate, .outputGate, .serialInputWord,
      .serialOutputWord
   );
   field_mem_model u_field_mem_model (
      .serialWriteClock, .serialReadClock, .writePointerReset, .readPointerReset,
      .writePointerGate, .writeDataGate, .readPointerGate, .outputGate, .serialInputWord,
      .serialOutputWord, .violations
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   task automatic check_word(input logic [11:0] e, input logic [11:0] g);
      cmpCount++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic check_flag(input logic e, input logic g);
      cmpCount++;
      if (g !== e) begin
         nFail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic pulse(input bit wr);
      @(negedge sys_clk);
      if (wr) writeFieldEnd = 1'b1;
      else readFieldStart = 1'b1;
      @(negedge sys_clk);
      writeFieldEnd = 1'b0;
      readFieldStart = 1'b0;
   endtask
   task automatic wait_pend(input bit wr, input int lim);
      int i;
      i = 0;
      while ((wr ? writeResetPending : readResetPending) !== 1'b0 && i < lim) begin
         @(negedge sys_clk);
         i++;
      end
      check_flag(1'b0, wr ? writeResetPending : readResetPending);
   endtask
   // Random gaps and random skipped locations; FIFO outruns the memory
   task automatic push(input bit rndStore);
      for (int i = 0; i < 100; i++) begin
         seed = lfsr(seed);
         if (seed[20] & seed[21]) begin
            inValid = 1'b0;
            @(negedge sys_clk);
         end
         w[i] = seed[11:0];
         st[i] = rndStore ? seed[12] | seed[13] : 1'b1;
         inValid = 1'b1;
         inData = w[i];
         inStore = st[i];
         while (inReady !== 1'b1) begin
            sawFull = 1'b1;
            @(negedge sys_clk);
         end
         @(negedge sys_clk);
      end
      inValid = 1'b0;
      // Let the FIFO drain: a write reset would overtake the words left in it
      repeat (40) @(negedge sys_clk);
      if (!rndStore) a = w;
   endtask
   task automatic collect(input bit merged);
      int i, k;
      for (i = 0; i < 100; i++) begin
         k = 0;
         while (outValid !== 1'b1 && k < 100) begin
            seed = lfsr(seed);
            readEnable = seed[3] | seed[4];
            @(negedge sys_clk);
            k++;
         end
         check_flag(1'b1, outValid);
         check_word(merged ? (st[i] ? w[i] : a[i]) : a[i], outData);
         @(negedge sys_clk);
      end
      readEnable = 1'b0;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      nFail++;
      wrap_up;
   end
   initial begin
      firstRise = 0;
      @(negedge rst);
      while (serialWriteClock !== 1'b1) begin
         @(negedge sys_clk);
         firstRise++;
      end
   end
   initial begin
      seed = 32'h0000A299;
      nFail = 0;
      cmpCount = 0;
      sawFull = 1'b0;
      rst = 1'b1;
      inValid = 1'b0;
      inData = 12'h000;
      inStore = 1'b0;
      writeFieldEnd = 1'b0;
      readFieldStart = 1'b0;
      readEnable = 1'b0;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      n = 0;
      while (initDone !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      check_flag(1'b1, initDone);
      check_flag(1'b1, firstRise >= 1000);
      $display("Test power-up done");
      // Dummy reads give the first read reset its 80 active cycles
      readEnable = 1'b1;
      push(1'b0);
      readEnable = 1'b0;
      check_flag(1'b1, sawFull);
      pulse(1'b1);
      wait_pend(1'b1, 400);
      $display("Test first field write done");
      pulse(1'b0);
      wait_pend(1'b0, 140);
      fork
         push(1'b1);
         collect(1'b0);
      join
      $display("Test old field read done");
      pulse(1'b1);
      wait_pend(1'b1, 400);
      repeat (200) @(negedge sys_clk);
      pulse(1'b0);
      repeat (100) @(negedge sys_clk);
      check_flag(1'b1, readResetPending);
      wait_pend(1'b0, 2000);
      collect(1'b1);
      check_flag(1'b0, violations != 0);
      $display("Test new field read done");
      wrap_up;
   end
endmodule
